/* design/irc_top.sv */
`timescale 1ns/10ps
module irc_top
  import irc_pkg::*;
(
  input  wire logic            REF_CLK,
  input  wire logic            ARST_N,
  input  wire logic            PERIPHERAL_SELECT_THREE_N,
  input  wire logic            WR,
  input  wire logic [9:2]      ADDR,
  input  wire logic [31:0]     WDATA,
  input  wire logic [15:1]     IRQ,
  input  wire logic [3:0]      INTERRUPT_LEVEL_CODE_IN,
  output logic      [31:0]     RDATA,
  output logic      [3:0]      INTERRUPT_LEVEL_CODE
);
  import irc_pkg::*;

  typedef struct packed {
    logic [15:1] prev;
    logic [15:1] pend;
    logic [15:0] trig_up;
    logic [15:2] trig_lo;
    logic [15:0] mask;
    logic [3:0]  level;
    logic [1:0]  mode;
    logic [31:0] rdata;
    logic [3:0]  interrupt_level_code;
  } irc_state_s;

  irc_state_s st;
  irc_state_s next_st;
  logic [15:1] irq_s;
  logic [3:0]  lvl_s;
  logic        rst_n;
  irc_bus_s    bus;

  // Reset release: two stages; the copy below gates everything else
  logic [1:0] rsync;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rsync <= 2'h0;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  irc_sync #(.W(15)) u_irq_sync (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .d     (IRQ),
    .q     (irq_s)
  );

  logic [3:0] lvl_q;
  irc_sync #(.W(4)) u_lvl_sync (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .d     (INTERRUPT_LEVEL_CODE_IN),
    .q     (lvl_q)
  );
  assign lvl_s = lvl_q;

  // Pins are sampled through the same stages as the request lines
  logic        sel_q;
  logic        wr_q;
  logic [7:0]  idx_q;
  logic [31:0] wd_q;
  irc_sync #(.W(42)) u_bus_sync (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .d     ({~PERIPHERAL_SELECT_THREE_N, WR, ADDR, WDATA}),
    .q     ({sel_q, wr_q, idx_q, wd_q})
  );
  assign bus.sel_n = ~sel_q;
  assign bus.wr    = wr_q;
  assign bus.idx   = idx_q;
  assign bus.wdata = wd_q;

  function automatic logic [1:0] trig_of(input logic [15:0] up, input logic [15:2] lo,
                                         input int ch);
    logic [31:0] all;
    all = {up, lo, 2'b00};
    return all[2*ch +: 2];
  endfunction

  function automatic logic [3:0] top_chan(input logic [15:1] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 1; i < NCH; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic acc;
  logic wr_acc;
  assign acc    = !bus.sel_n;
  assign wr_acc = acc && bus.wr;

  always_comb begin
    logic [1:0]  tm;
    logic        hit;
    logic [15:1] clr;
    tm  = 2'h0;
    hit = 1'b0;
    clr = '0;
    next_st = st;
    next_st.prev = irq_s;
    if (wr_acc && bus.idx == IDX_CLR) begin
      clr = bus.wdata[15:1];
    end
    for (int i = 1; i < NCH; i++) begin
      tm = trig_of(st.trig_up, st.trig_lo, i);
      unique case (irc_trig_e'(tm))
        TRIG_HIGH: hit = irq_s[i];
        TRIG_LOW:  hit = !irq_s[i];
        TRIG_RISE: hit = irq_s[i] && !st.prev[i];
        TRIG_FALL: hit = !irq_s[i] && st.prev[i];
      endcase
      // A level channel follows its input; edges stick until cleared, set wins
      if (tm[1] == 1'b0) begin
        next_st.pend[i] = hit;
      end else begin
        next_st.pend[i] = hit || (st.pend[i] && !clr[i]);
      end
    end
    // Latched level capture; clear wins only when no new level arrives
    if (lvl_s != 4'h0) begin
      next_st.level = lvl_s;
    end else if (wr_acc && bus.idx == IDX_LATCH && bus.wdata[LATCH_CLR_BIT]) begin
      next_st.level = RST_LEVEL;
    end
    if (wr_acc) begin
      unique case (bus.idx)
        IDX_TRIG_UP: next_st.trig_up = bus.wdata[15:0];
        IDX_TRIG_LO: next_st.trig_lo = bus.wdata[15:2];
        IDX_MASK:    next_st.mask    = bus.wdata[15:0];
        IDX_MODE:    next_st.mode    = bus.wdata[1:0];
        default:     hit = hit;
      endcase
    end
    next_st.rdata = 32'h0;
    if (acc && !bus.wr) begin
      unique case (bus.idx)
        IDX_TRIG_UP: next_st.rdata = {16'h0, st.trig_up};
        IDX_TRIG_LO: next_st.rdata = {16'h0, st.trig_lo, 2'b00};
        IDX_PEND:    next_st.rdata = {16'h0, st.pend, 1'b0};
        IDX_MASK:    next_st.rdata = {16'h0, st.mask};
        IDX_LATCH:   next_st.rdata = {28'h0, st.level};
        IDX_MODE:    next_st.rdata = {30'h0, st.mode};
        default:     next_st.rdata = 32'h0;
      endcase
    end
    next_st.interrupt_level_code = top_chan(st.pend & ~st.mask[15:1]);
    if (next_st.interrupt_level_code == 4'h0 && !st.mask[LVL_MASK_BIT]) begin
      next_st.interrupt_level_code = st.level;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0;
      st.trig_up <= RST_TRIG_UP;
      st.trig_lo <= RST_TRIG_LO[15:2];
      st.mask    <= RST_MASK;
      st.level   <= RST_LEVEL;
      st.mode    <= RST_MODE;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA = st.rdata;
  assign INTERRUPT_LEVEL_CODE = st.interrupt_level_code;

  chk_mask_reset_ones: assert property (@(posedge REF_CLK)
    $rose(rst_n) |-> st.mask == RST_MASK)
    else $error("channel masks not all set after reset");

  chk_pend_bit_zero: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    $past(acc && !bus.wr && bus.idx == IDX_PEND) |-> RDATA == {16'h0, $past(st.pend), 1'b0})
    else $error("pending read does not match flags");

  chk_clear_edge_flag: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (wr_acc && bus.idx == IDX_CLR && bus.wdata[15] && st.trig_up[15]
     && !(st.trig_up[14] ? (!irq_s[15] && st.prev[15]) : (irq_s[15] && !st.prev[15])))
    |=> !st.pend[15])
    else $error("clear did not drop edge flag");

  sequence s_rise15;
    st.trig_up[15:14] == 2'b10 ##0 irq_s[15] && !st.prev[15];
  endsequence
  chk_rise_sets: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    s_rise15 |=> st.pend[15])
    else $error("rising edge did not set flag");

  chk_level_follow: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    st.trig_up[15:14] == 2'b00 |=> st.pend[15] == $past(irq_s[15]))
    else $error("level channel flag does not follow input");

  chk_irl_top: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (st.pend[15] && !st.mask[15]) |=> INTERRUPT_LEVEL_CODE == 4'hf)
    else $error("highest channel not presented");

  chk_irl_idle: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    ((st.pend & ~st.mask[15:1]) == '0 && st.mask[0]) |=> INTERRUPT_LEVEL_CODE == 4'h0)
    else $error("masked latched level leaked");

  chk_latch_clear: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (wr_acc && bus.idx == IDX_LATCH && bus.wdata[LATCH_CLR_BIT] && lvl_s == 4'h0)
    |=> st.level == 4'h0)
    else $error("latched level not cleared");

  chk_no_select_read: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    bus.sel_n |=> RDATA == 32'h0)
    else $error("read data without select");

  chk_trig_write: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (wr_acc && bus.idx == IDX_TRIG_UP) |=> st.trig_up == $past(bus.wdata[15:0]))
    else $error("upper trigger write did not land");

  chk_mask_write: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (wr_acc && bus.idx == IDX_MASK) |=> st.mask == $past(bus.wdata[15:0]))
    else $error("mask write did not land");
endmodule

/* include/irc_pkg.sv */
// Contract
// - Registers answer only with select three low
// - Index 0x00 holds triggers, channels 15-8
// - Index 0x01 holds triggers 7-1, bits1:0 zero
// - Trigger codes: high, low, rise, fall; reset high
// - Index 0x02 reads pending flags 15-1
// - Index 0x03 write one clears edge-triggered pending flag; level flags follow input
// - Index 0x04 channel masks, one blocks, reset one
// - Mask bit zero gates latched level, reset zero
// - Index 0x05 reads four-bit latched level
// - Latch register bit four write clears level
package irc_pkg;
  localparam int NCH = 16;
  localparam logic [7:0] IDX_TRIG_UP  = 8'h00;
  localparam logic [7:0] IDX_TRIG_LO  = 8'h01;
  localparam logic [7:0] IDX_PEND     = 8'h02;
  localparam logic [7:0] IDX_CLR      = 8'h03;
  localparam logic [7:0] IDX_MASK     = 8'h04;
  localparam logic [7:0] IDX_LATCH    = 8'h05;
  localparam logic [7:0] IDX_MODE     = 8'h06;
  localparam int LATCH_CLR_BIT = 4;
  localparam int LVL_MASK_BIT  = 0;
  localparam logic [15:0] RST_TRIG_UP = 16'h0000;
  localparam logic [15:0] RST_TRIG_LO = 16'h0000;
  localparam logic [15:0] RST_MASK    = 16'hfffe;
  localparam logic [3:0]  RST_LEVEL   = 4'h0;
  localparam logic [1:0]  RST_MODE    = 2'h0;

  typedef enum logic [1:0] {
    TRIG_HIGH = 2'b00,
    TRIG_LOW  = 2'b01,
    TRIG_RISE = 2'b10,
    TRIG_FALL = 2'b11
  } irc_trig_e;

  typedef struct packed {
    logic        sel_n;
    logic        wr;
    logic [7:0]  idx;
    logic [31:0] wdata;
  } irc_bus_s;
endpackage

/* design/irc_sync.sv */
`timescale 1ns/10ps
module irc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } irc_sync_s;
  irc_sync_s st;
  irc_sync_s next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

/* verification/irc_src_model.sv */
`timescale 1ns/10ps
module irc_src_model (
  input  wire logic        clk,
  input  wire logic [15:1] req_cmd,
  input  wire logic [3:0]  lvl_cmd,
  output logic      [15:1] irq,
  output logic      [3:0]  lvl
);
  // Sources change just after the clock edge
  always_ff @(posedge clk) begin
    irq <= req_cmd;
    lvl <= lvl_cmd;
  end
endmodule

/* verification/irc_top_tb.sv */
`timescale 1ns/10ps
module irc_top_tb;
  import irc_pkg::*;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        sel_n = 1;
  logic        wr = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wd = 0;
  logic [31:0] rd;
  logic [31:0] q;
  logic [15:1] req = 0;
  logic [15:1] irq;
  logic [3:0]  lc = 0;
  logic [3:0]  li;
  logic [3:0]  lo;
  logic [15:0] p;
  logic [15:0] t;
  logic [15:0] e;
  logic [3:0]  v;
  int          err_total = 0;
  int          num_checks = 0;

  always #20 clk = ~clk;

  irc_src_model src (.clk(clk), .req_cmd(req), .lvl_cmd(lc), .irq(irq), .lvl(li));
  irc_top dut (.REF_CLK(clk), .ARST_N(rst_n), .PERIPHERAL_SELECT_THREE_N(sel_n),
    .WR(wr), .ADDR(adr), .WDATA(wd), .IRQ(irq), .INTERRUPT_LEVEL_CODE_IN(li),
    .RDATA(rd), .INTERRUPT_LEVEL_CODE(lo));

  function automatic logic [3:0] top_ch(input logic [15:0] f);
    top_ch = 4'h0;
    for (int i = 1; i < 16; i++) if (f[i]) top_ch = 4'(i);
  endfunction

  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("mismatch t=%0t read %h exp %h", $time, g, x);
    end
  endtask

  task automatic cmp_lvl(input logic [3:0] g, input logic [3:0] x);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("mismatch t=%0t level %h exp %h", $time, g, x);
    end
  endtask

  // One held access, then select high long enough to be seen idle
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) #1;
    sel_n = 0;
    wr = w;
    adr = a;
    wd = d;
    repeat (4) @(posedge clk);
    #1 q = rd;
    sel_n = 1;
    wr = 0;
    repeat (4) @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    cmp_rd(q, x);
  endtask

  task stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    $display("mismatch t=%0t watchdog expired", $time);
    err_total++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h76bae8b0));
    repeat (12) @(posedge clk);
    #1 rst_n = 1;
    repeat (4) @(posedge clk);
    rdchk(IDX_TRIG_UP, 32'h0);
    rdchk(IDX_TRIG_LO, 32'h0);
    rdchk(IDX_PEND, 32'h0);
    rdchk(IDX_CLR, 32'h0);
    rdchk(IDX_MASK, 32'hfffe);
    rdchk(IDX_LATCH, 32'h0);
    rdchk(8'h07, 32'h0);
    cmp_lvl(lo, 4'h0);
    // A write with select high must not land
    @(posedge clk) #1 wr = 1;
    adr = IDX_MASK;
    wd = 32'h0;
    repeat (6) @(posedge clk);
    #1 wr = 0;
    rdchk(IDX_MASK, 32'hfffe);
    rdchk(IDX_MODE, 32'h0);
    acc(1'b1, IDX_MODE, 32'h3);
    rdchk(IDX_MODE, 32'h3);
    acc(1'b1, IDX_MASK, 32'hffff);
    for (int k = 0; k < 4; k++) begin
      t = 16'($urandom);
      acc(1'b1, IDX_TRIG_UP, {16'h0, t});
      rdchk(IDX_TRIG_UP, {16'h0, t});
      acc(1'b1, IDX_TRIG_LO, {16'h0, t});
      rdchk(IDX_TRIG_LO, {16'h0, t & 16'hfffc});
    end
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, IDX_MASK, 32'hffff);
      t = {8{2'(m)}};
      acc(1'b1, IDX_TRIG_UP, {16'h0, t});
      acc(1'b1, IDX_TRIG_LO, {16'h0, t & 16'hfffc});
      @(posedge clk) #1 req = (m == 3) ? '1 : '0;
      p = {15'($urandom), 1'b0} | 16'h0002;
      acc(1'b1, IDX_CLR, 32'hfffe);
      @(posedge clk) #1 req = req ^ p[15:1];
      e = (m == 1) ? ~p & 16'hfffe : p;
      rdchk(IDX_PEND, {16'h0, e});
      @(posedge clk) #1 req = (m == 3) ? '1 : '0;
      e = m[1] ? p : ((m == 1) ? 16'hfffe : 16'h0);
      rdchk(IDX_PEND, {16'h0, e});
      acc(1'b1, IDX_MASK, 32'h0);
      cmp_lvl(lo, top_ch(e));
      acc(1'b1, IDX_CLR, {16'h0, p});
      rdchk(IDX_PEND, m[1] ? 32'h0 : {16'h0, e});
    end
    acc(1'b1, IDX_MASK, 32'hfffe);
    v = 4'($urandom_range(15, 1));
    @(posedge clk) #1 lc = v;
    repeat (6) @(posedge clk);
    #1 lc = 0;
    rdchk(IDX_LATCH, {28'h0, v});
    cmp_lvl(lo, v);
    acc(1'b1, IDX_MASK, 32'hffff);
    cmp_lvl(lo, 4'h0);
    acc(1'b1, IDX_LATCH, 32'h10);
    rdchk(IDX_LATCH, 32'h0);
    // Reset in mid-run: programmed triggers, masks and mode return to reset values
    @(posedge clk) #1 rst_n = 0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    repeat (4) @(posedge clk);
    rdchk(IDX_TRIG_UP, 32'h0);
    rdchk(IDX_TRIG_LO, 32'h0);
    rdchk(IDX_MASK, 32'hfffe);
    rdchk(IDX_MODE, 32'h0);
    cmp_lvl(lo, 4'h0);
    stop_test();
  end
endmodule
